// >>> bench/dasp_host.sv
// serial host model issuing register writes and reads
`timescale 1ns/1ps
`default_nettype none
module dasp_host (
  input  wire logic                        mclk,
  input  wire logic                        rvalid,
  input  wire logic [dasp_pkg::DATA_W-1:0] rdata,
  output logic                             wr_en,
  output logic                             rd_en,
  output logic [dasp_pkg::ADDR_W-1:0]      addr,
  output logic [dasp_pkg::DATA_W-1:0]      wdata
);
  import dasp_pkg::*;
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = '0;
    wdata = '0;
  end
  // released fields flip so stale values never look valid
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(negedge mclk);
    wr_en = 1'b1;
    addr = a;
    wdata = d;
    @(negedge mclk);
    wr_en = 1'b0;
    addr = ~a;
    wdata = ~d;
  endtask
  // data only taken while rvalid stands
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(negedge mclk);
    rd_en = 1'b1;
    addr = a;
    @(negedge mclk);
    d = rvalid ? rdata : 8'hxx;
    rd_en = 1'b0;
    addr = ~a;
  endtask
endmodule
`default_nettype wire

// >>> bench/dasp_regs_assertions.sv
// port-level checks on the register slice
`timescale 1ns/1ps
`default_nettype none
module dasp_regs_chk (
  input wire logic                        mclk,
  input wire logic                        srst,
  input wire logic                        wr_en,
  input wire logic                        rd_en,
  input wire logic                        sync_in,
  input wire logic                        output_enable_pin_n,
  input wire logic [dasp_pkg::NUM_CH-1:0] overrange_raw,
  input wire logic [dasp_pkg::DATA_W-1:0] rdata,
  input wire logic                        rvalid,
  input wire logic [15:0]                 pattern_one,
  input wire logic [15:0]                 pattern_two,
  input wire logic                        div_sync,
  input wire logic                        outputs_enabled,
  input wire logic                        sdio_pulldown_disable,
  input wire logic [dasp_pkg::NUM_CH-1:0] overrange_out
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  a_read_answer: assert property (rd_en |=> rvalid)
    else $error("read not answered");
  a_no_stray_valid: assert property (rvalid |-> $past(rd_en))
    else $error("rvalid without read");
  a_rdata_holds: assert property ($changed(rdata) |-> rvalid)
    else $error("rdata moved between reads");
  a_sync_cause: assert property (div_sync |-> $past(sync_in, 2))
    else $error("divider sync without pulse");
  a_oe_pin: assert property (!outputs_enabled |-> $past(output_enable_pin_n))
    else $error("outputs off with pin low");
  a_ovr_gate: assert property ((overrange_out & ~$past(overrange_raw)) == '0)
    else $error("overrange out without raw");
  a_patt_one_wr: assert property ($changed(pattern_one) |-> $past(wr_en, 2))
    else $error("pattern one moved unwritten");
  a_patt_two_wr: assert property ($changed(pattern_two) |-> $past(wr_en, 2))
    else $error("pattern two moved unwritten");
  a_pulldown_wr: assert property ($changed(sdio_pulldown_disable) |-> $past(wr_en, 2))
    else $error("pulldown bit moved unwritten");
  c_sync: cover property (div_sync);
  c_read: cover property (rvalid);
  c_oe_off: cover property (!outputs_enabled);
endmodule
bind dasp_regs dasp_regs_chk i_dasp_regs_chk (.*);
`default_nettype wire

// >>> bench/dual_adc_sync_pattern_regs_bench.sv
// self-checking bench for the sync and pattern register slice
`timescale 1ns/1ps
`default_nettype none
module dual_adc_sync_pattern_regs_bench;
  import dasp_pkg::*;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic wr_en, rd_en, rvalid, signature_bit, sync_in, output_enable_pin_n, low_rate_detected;
  logic div_sync, outputs_enabled, internal_low_rate_oscillator, sdio_pulldown_disable;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata, rd_val;
  logic [NUM_CH-1:0] chan_index, overrange_raw, overrange_out, conv_select;
  logic [15:0] pattern_one, pattern_two;
  int fails = 0;
  int compares = 0;
  int cycles = 0;
  int n = 0;
  always #2.5 mclk = ~mclk;
  dasp_regs i_dasp_regs (
    .mclk                         (mclk),
    .srst                         (srst),
    .wr_en                        (wr_en),
    .rd_en                        (rd_en),
    .addr                         (addr),
    .wdata                        (wdata),
    .chan_index                   (chan_index),
    .signature_bit                (signature_bit),
    .sync_in                      (sync_in),
    .output_enable_pin_n          (output_enable_pin_n),
    .low_rate_detected            (low_rate_detected),
    .overrange_raw                (overrange_raw),
    .rdata                        (rdata),
    .rvalid                       (rvalid),
    .pattern_one                  (pattern_one),
    .pattern_two                  (pattern_two),
    .div_sync                     (div_sync),
    .outputs_enabled              (outputs_enabled),
    .internal_low_rate_oscillator (internal_low_rate_oscillator),
    .sdio_pulldown_disable        (sdio_pulldown_disable),
    .overrange_out                (overrange_out),
    .conv_select                  (conv_select)
  );
  dasp_host i_dasp_host (
    .mclk   (mclk),
    .rvalid (rvalid),
    .rdata  (rdata),
    .wr_en  (wr_en),
    .rd_en  (rd_en),
    .addr   (addr),
    .wdata  (wdata)
  );
  task automatic end_sim();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (div_sync === 1'b1)
      n++;
    if (cycles == 4000) begin
      fails++;
      end_sim();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    i_dasp_host.rd(a, rd_val);
    chk({8'h00, rd_val}, {8'h00, exp});
  endtask
  task automatic t_reset_values();
    rchk(ADDR_PATT1_LOW, 8'h00);
    rchk(ADDR_PATT2_HIGH, 8'h00);
    rchk(ADDR_FEATURES, 8'h01);
    rchk(ADDR_OUT_ASSIGN, 8'h00);
    rchk(ADDR_SYNC_CTRL, 8'h01);
    rchk(ADDR_USER_CFG2, 8'h88);
    rchk(9'h0ff, 8'h00);
    chk({14'h0, conv_select}, 16'h0002);
  endtask
  task automatic t_patterns();
    i_dasp_host.wr(ADDR_PATT1_LOW, 8'h5a);
    i_dasp_host.wr(ADDR_PATT1_HIGH, 8'ha5);
    i_dasp_host.wr(ADDR_PATT2_LOW, 8'h3c);
    i_dasp_host.wr(ADDR_PATT2_HIGH, 8'hc3);
    i_dasp_host.wr(ADDR_SIGNATURE, 8'hff);
    repeat (2) @(negedge mclk);
    chk(pattern_one, 16'ha55a);
    chk(pattern_two, 16'hc33c);
    signature_bit = 1'b1;
    rchk(ADDR_SIGNATURE, 8'h01);
    signature_bit = 1'b0;
  endtask
  task automatic sync_run(input logic [7:0] ctrl, input int k, input int exp);
    i_dasp_host.wr(ADDR_SYNC_CTRL, ctrl);
    n = 0;
    repeat (k) begin
      @(negedge mclk);
      sync_in = 1'b1;
      @(negedge mclk);
      sync_in = 1'b0;
    end
    repeat (4) @(negedge mclk);
    chk(16'(n), 16'(exp));
  endtask
  task automatic t_sync();
    sync_run(8'h03, 3, 3);
    sync_run(8'h02, 2, 0);
    sync_run(8'h01, 2, 0);
    sync_run(8'h07, 3, 1);
    rchk(ADDR_SYNC_CTRL, 8'h05);
  endtask
  task automatic t_pins();
    output_enable_pin_n = 1'b1;
    repeat (2) @(negedge mclk);
    chk({15'h0, outputs_enabled}, 16'h0000);
    i_dasp_host.wr(ADDR_USER_CFG2, 8'h0d);
    repeat (2) @(negedge mclk);
    chk({13'h0, outputs_enabled, internal_low_rate_oscillator, sdio_pulldown_disable}, 16'h0007);
    i_dasp_host.wr(ADDR_USER_CFG2, 8'h08);
    low_rate_detected = 1'b1;
    repeat (2) @(negedge mclk);
    chk({15'h0, internal_low_rate_oscillator}, 16'h0001);
    low_rate_detected = 1'b0;
    repeat (2) @(negedge mclk);
    chk({14'h0, internal_low_rate_oscillator, sdio_pulldown_disable}, 16'h0000);
    output_enable_pin_n = 1'b0;
  endtask
  task automatic t_channels();
    overrange_raw = 2'b11;
    repeat (2) @(negedge mclk);
    chk({14'h0, overrange_out}, 16'h0003);
    i_dasp_host.wr(ADDR_FEATURES, 8'h00);
    repeat (2) @(negedge mclk);
    chk({14'h0, overrange_out}, 16'h0002);
    chan_index = 2'b10;
    i_dasp_host.wr(ADDR_OUT_ASSIGN, 8'h00);
    repeat (2) @(negedge mclk);
    chk({14'h0, conv_select}, 16'h0000);
    rchk(ADDR_FEATURES, 8'h01);
  endtask
  initial begin
    {signature_bit, sync_in, output_enable_pin_n, low_rate_detected} = 4'h0;
    chan_index = 2'b01;
    overrange_raw = 2'b00;
    repeat (12) @(negedge mclk);
    srst = 1'b0;
    t_reset_values();
    t_patterns();
    t_sync();
    t_pins();
    t_channels();
    end_sim();
  end
endmodule
`default_nettype wire

// >>> core/dasp_chan_regs.sv
// per-channel (locally indexed) features and output assign registers
`timescale 1ns/1ps
`default_nettype none
module dasp_chan_regs #(
  parameter logic [7:0] ASSIGN_RESET = 8'h00
) (
  input  wire logic mclk,
  input  wire logic srst,
  input  wire logic sel,
  input  wire logic wr_features,
  input  wire logic wr_assign,
  input  wire logic [dasp_pkg::DATA_W-1:0] wdata,
  output logic      ovr_enable,
  output logic      conv_select
);
  import dasp_pkg::*;

  // features overrange enable
  always_ff @(posedge mclk) begin
    if (srst) begin
      ovr_enable <= RST_FEATURES[FEAT_OVR_EN_BIT];
    end else if (sel && wr_features) begin
      ovr_enable <= wdata[FEAT_OVR_EN_BIT];
    end
  end

  // converter routing
  always_ff @(posedge mclk) begin
    if (srst) begin
      conv_select <= ASSIGN_RESET[ASSIGN_BIT];
    end else if (sel && wr_assign) begin
      conv_select <= wdata[ASSIGN_BIT];
    end
  end
endmodule
`default_nettype wire

// >>> core/dasp_pkg.sv
// register map and field constants for the sync/pattern register slice
package dasp_pkg;
  localparam int ADDR_W = 9;
  localparam int DATA_W = 8;

  localparam logic [8:0] ADDR_PATT1_LOW  = 9'h019;
  localparam logic [8:0] ADDR_PATT1_HIGH = 9'h01a;
  localparam logic [8:0] ADDR_PATT2_LOW  = 9'h01b;
  localparam logic [8:0] ADDR_PATT2_HIGH = 9'h01c;
  localparam logic [8:0] ADDR_SIGNATURE  = 9'h024;
  localparam logic [8:0] ADDR_FEATURES   = 9'h02a;
  localparam logic [8:0] ADDR_OUT_ASSIGN = 9'h02e;
  localparam logic [8:0] ADDR_SYNC_CTRL  = 9'h100;
  localparam logic [8:0] ADDR_USER_CFG2  = 9'h101;

  localparam logic [7:0] RST_PATT       = 8'h00;
  localparam logic [7:0] RST_FEATURES   = 8'h01;
  localparam logic [7:0] RST_ASSIGN_A   = 8'h00;
  localparam logic [7:0] RST_ASSIGN_B   = 8'h01;
  localparam logic [7:0] RST_SYNC_CTRL  = 8'h01;
  localparam logic [7:0] RST_USER_CFG2  = 8'h88;
  localparam logic [7:0] READ_ZERO      = 8'h00;

  localparam int SYNC_MASTER_BIT    = 0;
  localparam int SYNC_DIV_EN_BIT    = 1;
  localparam int SYNC_NEXT_ONLY_BIT = 2;
  localparam int SYNC_FIELD_W       = 3;
  localparam int FEAT_OVR_EN_BIT    = 0;
  localparam int ASSIGN_BIT         = 0;
  localparam int CFG2_OE_PIN_BIT    = 7;
  localparam int CFG2_DETECT_BIT    = 3;
  localparam int CFG2_RUN_OSC_BIT   = 2;
  localparam int CFG2_NO_PULL_BIT   = 0;
  localparam logic [7:0] CFG2_MASK  = 8'h8d;
  localparam int SIG_BIT            = 0;

  localparam int NUM_CH = 2;
endpackage

// >>> core/dasp_regs.sv
// register slice: test patterns, signature, per-channel pins, sync and user config
// Functional notes
// [R1] no sync function acts unless master sync enable is one
// [R2] divider enable gates sync pulses; continuous mode when next-only is low
// [R3] next-only mode aligns to first pulse and ignores later ones
// [R4] divider sync enable clears itself after a next-only sync
// [R5] user config bit 7 enables the output-enable pin, else ignored
// [R6] features bit 0 enables indexed channel overrange pin, reset enabled
// [R7] pattern one is 16 bits, low byte then high byte
// [R8] pattern two is 16 bits in two bytes, both reset zero
// [R9] detect bit starts oscillator when encode rate is low
// [R10] run bit forces the oscillator on regardless of detector
// [R11] bit 0 set disables serial data pin pull-down
// [R12] output assign bit 0 picks converter A or B per channel
`timescale 1ns/1ps
`default_nettype none
module dasp_regs (
  input  wire logic                        mclk,
  input  wire logic                        srst,
  input  wire logic                        wr_en,
  input  wire logic                        rd_en,
  input  wire logic [dasp_pkg::ADDR_W-1:0] addr,
  input  wire logic [dasp_pkg::DATA_W-1:0] wdata,
  input  wire logic [dasp_pkg::NUM_CH-1:0] chan_index,
  input  wire logic                        signature_bit,
  input  wire logic                        sync_in,
  input  wire logic                        output_enable_pin_n,
  input  wire logic                        low_rate_detected,
  input  wire logic [dasp_pkg::NUM_CH-1:0] overrange_raw,
  output logic [dasp_pkg::DATA_W-1:0]      rdata,
  output logic                             rvalid,
  output logic [15:0]                      pattern_one,
  output logic [15:0]                      pattern_two,
  output logic                             div_sync,
  output logic                             outputs_enabled,
  output logic                             internal_low_rate_oscillator,
  output logic                             sdio_pulldown_disable,
  output logic [dasp_pkg::NUM_CH-1:0]      overrange_out,
  output logic [dasp_pkg::NUM_CH-1:0]      conv_select
);
  import dasp_pkg::*;

  logic [DATA_W-1:0]       patt1_lo;
  logic [DATA_W-1:0]       patt1_hi;
  logic [DATA_W-1:0]       patt2_lo;
  logic [DATA_W-1:0]       patt2_hi;
  logic [DATA_W-1:0]       user_cfg2;
  logic [SYNC_FIELD_W-1:0] sync_ctrl;
  logic                    sig_byte;
  logic [NUM_CH-1:0]       ovr_en;
  logic [NUM_CH-1:0]       sel_conv;
  logic                    wr_features;
  logic                    wr_assign;
  logic                    wr_sync;
  logic                    div_sync_i;
  logic [DATA_W-1:0]       next_rdata;
  logic [NUM_CH-1:0]       first_ch;

  assign wr_features = wr_en && (addr == ADDR_FEATURES);
  assign wr_assign   = wr_en && (addr == ADDR_OUT_ASSIGN);
  assign wr_sync     = wr_en && (addr == ADDR_SYNC_CTRL);
  // reads of local registers show the lowest indexed channel
  assign first_ch    = chan_index & (~chan_index + NUM_CH'(1));

  // [R6] per-channel local registers
  // [R12] per-channel converter routing
  generate
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      dasp_chan_regs #(
        .ASSIGN_RESET ((c == 0) ? RST_ASSIGN_A : RST_ASSIGN_B)
      ) u_ch (
        .mclk        (mclk),
        .srst        (srst),
        .sel         (chan_index[c]),
        .wr_features (wr_features),
        .wr_assign   (wr_assign),
        .wdata       (wdata),
        .ovr_enable  (ovr_en[c]),
        .conv_select (sel_conv[c])
      );
    end
  endgenerate

  dasp_sync_ctrl u_sync (
    .mclk     (mclk),
    .srst     (srst),
    .wr_en    (wr_sync),
    .wdata    (wdata),
    .sync_in  (sync_in),
    .ctrl     (sync_ctrl),
    .div_sync (div_sync_i)
  );

  // [R7] pattern one bytes
  always_ff @(posedge mclk) begin
    if (srst) begin
      patt1_lo <= RST_PATT;
      patt1_hi <= RST_PATT;
    end else if (wr_en && addr == ADDR_PATT1_LOW) begin
      patt1_lo <= wdata;
    end else if (wr_en && addr == ADDR_PATT1_HIGH) begin
      patt1_hi <= wdata;
    end
  end

  // [R8] pattern two bytes
  always_ff @(posedge mclk) begin
    if (srst) begin
      patt2_lo <= RST_PATT;
      patt2_hi <= RST_PATT;
    end else if (wr_en && addr == ADDR_PATT2_LOW) begin
      patt2_lo <= wdata;
    end else if (wr_en && addr == ADDR_PATT2_HIGH) begin
      patt2_hi <= wdata;
    end
  end

  // open bits are not stored, they read as zero
  always_ff @(posedge mclk) begin
    if (srst) begin
      user_cfg2 <= RST_USER_CFG2;
    end else if (wr_en && addr == ADDR_USER_CFG2) begin
      user_cfg2 <= wdata & CFG2_MASK;
    end
  end

  // signature byte is read-only, captured from the checker
  always_ff @(posedge mclk) begin
    if (srst) begin
      sig_byte <= 1'b0;
    end else begin
      sig_byte <= signature_bit;
    end
  end

  always_comb begin
    next_rdata = READ_ZERO;
    unique case (addr)
      ADDR_PATT1_LOW:  next_rdata = patt1_lo;
      ADDR_PATT1_HIGH: next_rdata = patt1_hi;
      ADDR_PATT2_LOW:  next_rdata = patt2_lo;
      ADDR_PATT2_HIGH: next_rdata = patt2_hi;
      ADDR_SIGNATURE:  next_rdata[SIG_BIT] = sig_byte;
      ADDR_FEATURES:   next_rdata[FEAT_OVR_EN_BIT] = |(ovr_en & first_ch);
      ADDR_OUT_ASSIGN: next_rdata[ASSIGN_BIT] = |(sel_conv & first_ch);
      ADDR_SYNC_CTRL:  next_rdata[SYNC_FIELD_W-1:0] = sync_ctrl;
      ADDR_USER_CFG2:  next_rdata = user_cfg2;
      default:         next_rdata = READ_ZERO;
    endcase
  end

  // registered read, one cycle after rd_en
  always_ff @(posedge mclk) begin
    if (srst) begin
      rdata  <= READ_ZERO;
      rvalid <= 1'b0;
    end else begin
      rvalid <= rd_en;
      if (rd_en) begin
        rdata <= next_rdata;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      pattern_one <= {RST_PATT, RST_PATT};
      pattern_two <= {RST_PATT, RST_PATT};
    end else begin
      pattern_one <= {patt1_hi, patt1_lo};
      pattern_two <= {patt2_hi, patt2_lo};
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      div_sync <= 1'b0;
    end else begin
      div_sync <= div_sync_i;
    end
  end

  // [R5] pin ignored when bit clear
  always_ff @(posedge mclk) begin
    if (srst) begin
      outputs_enabled <= 1'b1;
    end else begin
      outputs_enabled <= !(user_cfg2[CFG2_OE_PIN_BIT] && output_enable_pin_n);
    end
  end

  // [R9] detector start
  // [R10] run overrides detector
  always_ff @(posedge mclk) begin
    if (srst) begin
      internal_low_rate_oscillator <= 1'b0;
    end else begin
      internal_low_rate_oscillator <= user_cfg2[CFG2_RUN_OSC_BIT]
                                   || (user_cfg2[CFG2_DETECT_BIT] && low_rate_detected);
    end
  end

  // [R11] pull-down disable
  always_ff @(posedge mclk) begin
    if (srst) begin
      sdio_pulldown_disable <= 1'b0;
    end else begin
      sdio_pulldown_disable <= user_cfg2[CFG2_NO_PULL_BIT];
    end
  end

  // [R6] gate overrange pins
  always_ff @(posedge mclk) begin
    if (srst) begin
      overrange_out <= '0;
      conv_select   <= {RST_ASSIGN_B[ASSIGN_BIT], RST_ASSIGN_A[ASSIGN_BIT]};
    end else begin
      overrange_out <= overrange_raw & ovr_en;
      conv_select   <= sel_conv;
    end
  end
endmodule
`default_nettype wire

// >>> core/dasp_sync_ctrl.sv
// global sync control register and divider sync gating
`timescale 1ns/1ps
`default_nettype none
module dasp_sync_ctrl (
  input  wire logic mclk,
  input  wire logic srst,
  input  wire logic wr_en,
  input  wire logic [dasp_pkg::DATA_W-1:0] wdata,
  input  wire logic sync_in,
  output logic [dasp_pkg::SYNC_FIELD_W-1:0] ctrl,
  output logic      div_sync
);
  import dasp_pkg::*;

  logic master;
  logic div_en;
  logic next_only;
  logic pass;

  assign master    = ctrl[SYNC_MASTER_BIT];
  assign div_en    = ctrl[SYNC_DIV_EN_BIT];
  assign next_only = ctrl[SYNC_NEXT_ONLY_BIT];
  // [R1] master gates everything
  // [R2] divider enable gates pulse
  assign pass = master && div_en && sync_in;

  // [R3] one-shot clears after first
  // [R4] self-clear beats write
  always_ff @(posedge mclk) begin
    if (srst) begin
      ctrl <= RST_SYNC_CTRL[SYNC_FIELD_W-1:0];
    end else if (wr_en) begin
      ctrl <= wdata[SYNC_FIELD_W-1:0];
      if (pass && next_only) begin
        ctrl[SYNC_DIV_EN_BIT] <= 1'b0;
      end
    end else if (pass && next_only) begin
      ctrl[SYNC_DIV_EN_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      div_sync <= 1'b0;
    end else begin
      div_sync <= pass;
    end
  end
endmodule
`default_nettype wire
